// ==== bench/corr_math_monitor.sv ====
// Concurrent checks on the correction datapath ports
`timescale 1ns/100ps
module corr_math_monitor (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_nrst,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  // Controls and status
  input wire logic        o_guard_drive_enable,
  input wire logic        o_difference_mode_enable,
  input wire logic        o_noise_mode,
  input wire logic [4:0]  o_cap_res_bits,
  input wire logic [4:0]  o_temp_res_bits,
  input wire logic [18:0] o_cap_conv_cycles,
  input wire logic        o_busy,
  input wire logic        o_sat
);
  // ==========================================================================
  // Write capture
  logic        wr_acc;
  logic [31:0] wd_q;
  assign wr_acc = i_psel && i_penable && i_pwrite && o_pready;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) wd_q <= '0;
    else if (wr_acc) wd_q <= i_pwdata;
  end
  function automatic logic [18:0] conv_cyc(input logic [4:0] r, input logic n);
    int i;
    i = (int'(r) - 12) / 2;
    return 19'((n ? corr_pkg::T_N1[i] : corr_pkg::T_N0[i]) * corr_pkg::CLK_MHZ);
  endfunction : conv_cyc
  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  property p_conv_time;
    $stable(o_cap_res_bits) && $stable(o_noise_mode)
      && (o_cap_res_bits inside {5'd12, 5'd14, 5'd16, 5'd18})
      |-> o_cap_conv_cycles == conv_cyc(o_cap_res_bits, o_noise_mode);
  endproperty
  a_conv_time: assert property (p_conv_time) else $error("Conversion cycles wrong");
  property p_temp_res;
    $past(i_nrst) |-> o_temp_res_bits == 5'd14;
  endproperty
  a_temp_res: assert property (p_temp_res) else $error("Temperature resolution wrong");
  property p_res_default;
    !$past(i_nrst) |=> o_cap_res_bits == 5'd16;
  endproperty
  a_res_default: assert property (p_res_default) else $error("Default resolution wrong");
  property p_res_write;
    wr_acc && i_paddr == corr_pkg::A_CFG12
      |-> ##[1:2] o_cap_res_bits == 5'd12 + {2'b00, wd_q[7:6], 1'b0};
  endproperty
  a_res_write: assert property (p_res_write) else $error("Resolution not applied");
  property p_noise_write;
    wr_acc && i_paddr == corr_pkg::A_CFG12 |-> ##[1:2] o_noise_mode == wd_q[8];
  endproperty
  a_noise_write: assert property (p_noise_write) else $error("Noise mode not applied");
  property p_shield_write;
    wr_acc && i_paddr == corr_pkg::A_CFG19 |-> ##[1:2]
      (o_guard_drive_enable == wd_q[4] && o_difference_mode_enable == wd_q[3]);
  endproperty
  a_shield_write: assert property (p_shield_write) else $error("Sub-mode not applied");
  property p_sat_rise;
    $rose(o_sat) |-> $past(o_busy) || $past(o_busy, 2);
  endproperty
  a_sat_rise: assert property (p_sat_rise) else $error("Saturation set outside measurement");
  property p_busy_bound;
    $rose(o_busy) |-> ##[1:40] !o_busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("Busy too long");
  property p_pready_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("Ready longer than one cycle");
  c_measure: cover property ($fell(o_busy));
  c_sat: cover property ($rose(o_sat));
  c_cfg: cover property (wr_acc && i_paddr == corr_pkg::A_CFG12);
endmodule : corr_math_monitor
bind corr_math corr_math_monitor u_monitor (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_guard_drive_enable(o_guard_drive_enable), .o_noise_mode(o_noise_mode),
  .o_difference_mode_enable(o_difference_mode_enable), .o_cap_res_bits(o_cap_res_bits),
  .o_temp_res_bits(o_temp_res_bits), .o_cap_conv_cycles(o_cap_conv_cycles),
  .o_busy(o_busy), .o_sat(o_sat));

// ==== bench/frontend_model.sv ====
// Converter front-end model presenting raw readings
`timescale 1ns/100ps
module frontend_model (
  // Control
  input wire logic        i_busy,
  input wire logic [25:0] i_cap_val,
  input wire logic [25:0] i_temp_val,
  // Readings
  output logic [25:0]     o_sraw,
  output logic [25:0]     o_traw
);
  // Readings hold while idle and change while the datapath works
  assign o_sraw = i_busy ? ~i_cap_val : i_cap_val;
  assign o_traw = i_busy ? ~i_temp_val : i_temp_val;
endmodule : frontend_model

// ==== bench/testbench.sv ====
// Self-checking testbench for the correction datapath
`timescale 1ns/100ps
module testbench;
  // ==========================================================================
  // Signals
  localparam logic [23:0] NIL = 24'h0;
  logic        i_core_clk, i_nrst, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rdata;
  logic        o_pready, o_pslverr, o_guard_drive_enable, o_difference_mode_enable;
  logic        o_noise_mode, o_busy, o_sat, perr;
  logic [4:0]  o_cap_res_bits, o_temp_res_bits;
  logic [18:0] o_cap_conv_cycles;
  logic [25:0] i_sraw, i_traw, cap_val, temp_val;
  int          miscompares, comparisons, cycles;
  corr_math DUT (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sraw(i_sraw), .i_traw(i_traw),
    .o_guard_drive_enable(o_guard_drive_enable), .o_noise_mode(o_noise_mode),
    .o_difference_mode_enable(o_difference_mode_enable), .o_cap_res_bits(o_cap_res_bits),
    .o_temp_res_bits(o_temp_res_bits), .o_cap_conv_cycles(o_cap_conv_cycles),
    .o_busy(o_busy), .o_sat(o_sat));
  frontend_model u_frontend (
    .i_busy(o_busy), .i_cap_val(cap_val), .i_temp_val(temp_val),
    .o_sraw(i_sraw), .o_traw(i_traw));
  // ==========================================================================
  // Clock and timeout
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========================================================================
  // Tasks
  task final_report;
    if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    rdata     = o_prdata;
    perr      = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task scen(input logic [15:0] cfg, input logic [23:0] gain, ofs, tcg, ssen, shift,
            input logic [25:0] cap, temp, input logic [2:0] cmd, input logic [25:0] exp,
            input logic sat);
    logic [23:0] cf [9];
    cf = '{gain, ofs, tcg, NIL, NIL, NIL, ssen, shift, NIL};
    apb(1'b1, corr_pkg::A_CFG02, {16'h0, cfg});
    for (int i = 0; i < 9; i++) apb(1'b1, corr_pkg::A_COEF0 + 8'(4 * i), {8'h0, cf[i]});
    cap_val  <= cap;
    temp_val <= temp;
    apb(1'b1, corr_pkg::A_CTRL, {29'h0, cmd});
    apb(1'b0, corr_pkg::A_STATUS, 32'h0);
    check("busy", {31'h0, rdata[corr_pkg::B_BUSY]}, 32'h1);
    while (o_busy !== 1'b0) @(posedge i_core_clk);
    apb(1'b0, corr_pkg::A_RESULT, 32'h0);
    check("result", rdata, {6'h0, exp});
    apb(1'b0, corr_pkg::A_STATUS, 32'h0);
    check("status_sat", {31'h0, rdata[corr_pkg::B_SAT]}, {31'h0, sat});
    check("o_sat", {31'h0, o_sat}, {31'h0, sat});
  endtask : scen
  // ==========================================================================
  // Main sequence
  initial begin
    i_nrst = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h0;
    i_pwdata = 32'h0;
    cap_val = 26'h0;
    temp_val = 26'h0;
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    apb(1'b0, corr_pkg::A_CFG12, 32'h0);
    check("cfg12_reset", rdata, 32'h0000_0080);
    check("res_reset", {27'h0, o_cap_res_bits}, 32'h10);
    check("temp_res", {27'h0, o_temp_res_bits}, 32'he);
    check("conv_reset", {13'h0, o_cap_conv_cycles}, 32'(2390 * 40));
    for (int r = 0; r < 4; r++)
      for (int n = 0; n < 2; n++) begin
        apb(1'b1, corr_pkg::A_CFG12, 32'(32'h8000 | (n << 8) | (r << 6)));
        repeat (2) @(posedge i_core_clk);
        check("res", {27'h0, o_cap_res_bits}, 32'(12 + 2 * r));
        check("noise", {31'h0, o_noise_mode}, 32'(n));
        check("conv", {13'h0, o_cap_conv_cycles},
              32'((n ? corr_pkg::T_N1[r] : corr_pkg::T_N0[r]) * 40));
      end
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, corr_pkg::A_CFG19, 32'(g << 3));
      repeat (2) @(posedge i_core_clk);
      check("guard", {31'h0, o_guard_drive_enable}, 32'(g >> 1));
      check("diff", {31'h0, o_difference_mode_enable}, 32'(g & 1));
    end
    apb(1'b0, corr_pkg::A_CFG19, 32'h0);
    check("cfg19_read", rdata, 32'h0000_0018);
    apb(1'b0, 8'h48, 32'h0);
    check("unmapped", {31'h0, perr}, 32'h1);
    apb(1'b1, corr_pkg::A_CFG12, 32'h0000_8080);
    apb(1'b0, corr_pkg::A_CONVT, 32'h0);
    check("convt_read", rdata, 32'(corr_pkg::T_N0[2] * corr_pkg::CLK_MHZ));
    scen(16'h0, 24'h200000, NIL, NIL, NIL, 24'h000100, 26'h0100000, 26'h0, 3'b001,
         26'h0900400, 1'b0);
    scen(16'h0, 24'ha00000, NIL, NIL, NIL, NIL, 26'h0100000, 26'h0, 3'b001,
         26'h0700000, 1'b0);
    scen(16'h0, 24'h200000, 24'h040000, 24'h200000, NIL, NIL, 26'h0100000, 26'h0800000,
         3'b001, 26'h0c00000, 1'b0);
    scen(16'h0, NIL, NIL, NIL, 24'h100000, NIL, 26'h0, 26'h0, 3'b001,
         26'h0c00000, 1'b0);
    scen(16'h0, 24'h200000, NIL, NIL, NIL, NIL, 26'h1ffffff, 26'h0, 3'b001,
         26'h1ffffff, 1'b1);
    apb(1'b1, corr_pkg::A_CTRL, 32'h4);
    while (o_busy !== 1'b0) @(posedge i_core_clk);
    apb(1'b0, corr_pkg::A_STATUS, 32'h0);
    check("sat_cleared", {31'h0, rdata[corr_pkg::B_SAT]}, 32'h0);
    scen(16'h0, 24'h200000, NIL, NIL, NIL, NIL, 26'h3000000, 26'h0, 3'b001,
         26'h0, 1'b1);
    scen(16'h0800, 24'h200000, NIL, NIL, NIL, NIL, 26'h0400000, 26'h0, 3'b001,
         26'h0800000, 1'b0);
    scen(16'h0800, 24'h200000, NIL, NIL, NIL, NIL, 26'h0400000, 26'h0, 3'b010,
         26'h0400000, 1'b0);
    scen(16'h8000, 24'h200000, NIL, NIL, 24'h200000, NIL, 26'h3c00000, 26'h0, 3'b001,
         26'h0200000, 1'b0);
    final_report();
  end
endmodule : testbench

// ==== hdl/corr_add.sv ====
// Three-input saturating adder with optional positive clamp
`timescale 1ns/100ps
module corr_add (
  // Operands
  input  wire logic signed [25:0] i_a,
  input  wire logic signed [25:0] i_b,
  input  wire logic signed [25:0] i_c,
  input  wire logic               i_pos,
  // Result
  output logic signed [25:0]      o_s,
  output logic                    o_sat
);
  logic signed [27:0] sum;
  always_comb begin
    sum   = 28'(i_a) + 28'(i_b) + 28'(i_c);
    o_sat = 1'b0;
    o_s   = sum[25:0];
    if (sum > 28'(corr_pkg::MAX_V)) begin
      o_s   = corr_pkg::MAX_V;
      o_sat = 1'b1;
    end else if (i_pos && sum < 28'sd0) begin
      o_s   = '0;
      o_sat = 1'b1;
    end else if (sum < 28'(corr_pkg::MIN_V)) begin
      o_s   = corr_pkg::MIN_V;
      o_sat = 1'b1;
    end
  end
endmodule : corr_add

// ==== hdl/corr_math.sv ====
// Capacitive sensor correction datapath with APB register file
`timescale 1ns/100ps
module corr_math (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Converter front-end
  input  wire logic [25:0] i_sraw,
  input  wire logic [25:0] i_traw,
  // Front-end controls
  output logic             o_guard_drive_enable,
  output logic             o_difference_mode_enable,
  output logic             o_noise_mode,
  output logic [4:0]       o_cap_res_bits,
  output logic [4:0]       o_temp_res_bits,
  output logic [18:0]      o_cap_conv_cycles,
  // Status
  output logic             o_busy,
  output logic             o_sat
);
  // ==========================================================================
  // Registers
  logic [15:0]             cfg02_q, cfg12_q, cfg19_q;
  logic [23:0]             coef_q [corr_pkg::N_COEF];
  logic signed [25:0]      sraw_q, traw_q, res_q, acc_q, k1_q, k2_q, z_q;
  logic                    raw_q, sat_q, sat_acc_q, busy_q;
  corr_pkg::state_t        st_q;
  logic                    wr_en, rd_en, hit;
  logic [31:0]             rdat;
  // ==========================================================================
  // Coefficient decode: sign-magnitude to 26-bit, shifted left by two
  function automatic logic signed [25:0] cvt(input logic [23:0] c);
    logic signed [25:0] m;
    m = {1'b0, c[corr_pkg::MAG_W-1:0], 2'b00};
    return c[corr_pkg::CW-1] ? -m : m;
  endfunction : cvt
  logic signed [25:0] c_gain, c_ofs, c_tcg, c_tco, c_stcg, c_stco, c_ssen, c_shift;
  assign c_gain  = cvt(coef_q[corr_pkg::C_GAIN]);
  assign c_ofs   = cvt(coef_q[corr_pkg::C_OFS]);
  assign c_tcg   = cvt(coef_q[corr_pkg::C_TCG]);
  assign c_tco   = cvt(coef_q[corr_pkg::C_TCO]);
  assign c_stcg  = cvt(coef_q[corr_pkg::C_STCG]);
  assign c_stco  = cvt(coef_q[corr_pkg::C_STCO]);
  assign c_ssen  = cvt(coef_q[corr_pkg::C_SSEN]);
  assign c_shift = cvt(coef_q[corr_pkg::C_SHIFT]);
  // ==========================================================================
  // Inversion: 2^24 - 2^46/x, clamped
  logic signed [25:0] inv_v;
  logic               inv_sat;
  always_comb begin
    logic [47:0] q;
    logic [25:0] ax;
    logic signed [49:0] r;
    q = '0;
    ax = '0;
    r = '0;
    ax = sraw_q[25] ? 26'(-sraw_q) : sraw_q;
    inv_sat = 1'b0;
    inv_v   = corr_pkg::MAX_V;
    if (ax == 26'h0) begin
      inv_sat = 1'b1;
    end else begin
      q = corr_pkg::INV_NUM / 48'(ax);
      r = sraw_q[25] ? 50'(corr_pkg::INV_OFS) + 50'(q) : 50'(corr_pkg::INV_OFS) - 50'(q);
      if (r > 50'(corr_pkg::MAX_V)) begin
        inv_sat = 1'b1;
      end else if (r < 50'(corr_pkg::MIN_V)) begin
        inv_v   = corr_pkg::MIN_V;
        inv_sat = 1'b1;
      end else begin
        inv_v = r[25:0];
      end
    end
  end
  // ==========================================================================
  // Shared multipliers and adders, steered by state
  logic signed [25:0] ma, mb, mc, md, p1, p2, aa, ab, ac, s1;
  logic               m1s, m2s, a1s, apos;
  logic               shape;
  assign shape = cfg02_q[corr_pkg::B_SHAPE];
  logic signed [25:0] absz;
  assign absz = z_q[25] ? ((z_q == corr_pkg::MIN_V) ? corr_pkg::MAX_V : -z_q) : z_q;
  corr_mul #(.SH(corr_pkg::SCALE_SH)) u_m1 (.i_a(ma), .i_b(mb), .o_p(p1), .o_sat(m1s));
  corr_mul #(.SH(corr_pkg::SCALE_SH)) u_m2 (.i_a(mc), .i_b(md), .o_p(p2), .o_sat(m2s));
  corr_add u_a1 (.i_a(aa), .i_b(ab), .i_c(ac), .i_pos(apos), .o_s(s1), .o_sat(a1s));
  always_comb begin
    ma   = '0;
    mb   = '0;
    mc   = '0;
    md   = '0;
    aa   = '0;
    ab   = '0;
    ac   = '0;
    apos = 1'b0;
    case (st_q)
      corr_pkg::ST_TEMP: begin
        // K1 inner: second-order gain tempco term plus gain tempco
        ma = c_stcg;
        mb = traw_q;
        aa = p1;
        ab = c_tcg;
      end
      corr_pkg::ST_GAIN: begin
        // K1*K2/2^23 feeds the gain product directly
        ma   = k1_q;
        mb   = k2_q;
        mc   = c_gain;
        md   = p1;
        aa   = p2;
        ab   = shape ? '0 : corr_pkg::ONE_V;
        apos = !shape;
      end
      corr_pkg::ST_OUT: begin
        // Inner second-order factor plus one
        ma = c_ssen;
        mb = shape ? absz : z_q;
        aa = p1;
        ab = corr_pkg::ONE_V;
      end
      corr_pkg::ST_DONE: begin
        // Final product, shift and S-shape midpoint
        mc   = z_q;
        md   = acc_q;
        aa   = p2;
        ab   = c_shift;
        ac   = shape ? corr_pkg::ONE_V : '0;
        apos = 1'b1;
      end
      default: begin
        ma = '0;
      end
    endcase
  end
  // Second products for the temperature stage
  logic signed [25:0] t_in2, k1v, k2v, q1, q2;
  logic               ks1, ks2, tq1, tq2, ks3;
  corr_mul #(.SH(corr_pkg::SCALE_SH)) u_m3 (.i_a(c_stco), .i_b(traw_q), .o_p(q1), .o_sat(tq1));
  corr_add u_a2 (.i_a(q1), .i_b(c_tco), .i_c(26'sh0), .i_pos(1'b0), .o_s(t_in2), .o_sat(ks3));
  corr_mul #(.SH(corr_pkg::SCALE_SH)) u_m4 (.i_a(traw_q), .i_b(s1), .o_p(q2), .o_sat(tq2));
  logic signed [25:0] mc_t;
  corr_mul #(.SH(corr_pkg::SCALE_SH)) u_m5 (.i_a(traw_q), .i_b(t_in2), .o_p(mc_t), .o_sat(ks1));
  corr_add u_a3 (.i_a(corr_pkg::ONE_V), .i_b(q2), .i_c(26'sh0), .i_pos(1'b0), .o_s(k1v),
                 .o_sat(ks2));
  logic signed [25:0] k2a;
  logic               k2s;
  corr_add u_a4 (.i_a(c_ofs), .i_b(acc_q), .i_c(mc_t), .i_pos(1'b0), .o_s(k2a), .o_sat(k2s));
  // Gain stage scale: parabolic uses 4*gain/2^23, S-shape gain/2^21
  logic signed [25:0] gz;
  logic               gzs;
  logic signed [25:0] coef_q_gain_raw;
  assign coef_q_gain_raw = c_gain >>> corr_pkg::LOAD_SH;
  corr_mul #(.SH(corr_pkg::GAIN_SH)) u_m6 (.i_a(coef_q_gain_raw), .i_b(p1), .o_p(gz), .o_sat(gzs));
  // ==========================================================================
  // Sequencer
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q      <= corr_pkg::ST_IDLE;
      busy_q    <= 1'b0;
      sat_acc_q <= 1'b0;
      sat_q     <= 1'b0;
      raw_q     <= 1'b0;
      res_q     <= '0;
      acc_q     <= '0;
      k1_q      <= '0;
      k2_q      <= '0;
      z_q       <= '0;
    end else begin
      case (st_q)
        corr_pkg::ST_IDLE: begin
          if (wr_en && i_paddr == corr_pkg::A_CTRL) begin
            if (i_pwdata[corr_pkg::B_START] || i_pwdata[corr_pkg::B_RAWCMD]) begin
              busy_q    <= 1'b1;
              raw_q     <= i_pwdata[corr_pkg::B_RAWCMD];
              sat_acc_q <= 1'b0;
              acc_q     <= sraw_q;
              st_q      <= corr_pkg::ST_INV;
            end else if (i_pwdata[corr_pkg::B_OTHER]) begin
              sat_q <= 1'b0;
            end
          end
        end
        corr_pkg::ST_INV: begin
          if (cfg02_q[corr_pkg::B_INV] && !raw_q) begin
            acc_q     <= inv_v;
            sat_acc_q <= inv_sat;
          end
          st_q <= raw_q ? corr_pkg::ST_DONE : corr_pkg::ST_TEMP;
          if (raw_q) begin
            res_q <= sraw_q;
          end
        end
        corr_pkg::ST_TEMP: begin
          k1_q      <= k1v;
          k2_q      <= k2a;
          sat_acc_q <= sat_acc_q | m1s | a1s | tq1 | tq2 | ks1 | ks2 | ks3 | k2s;
          st_q      <= corr_pkg::ST_GAIN;
        end
        corr_pkg::ST_GAIN: begin
          acc_q     <= p1;
          z_q       <= shape ? gz : s1;
          sat_acc_q <= sat_acc_q | m1s | (shape ? gzs : (m2s | a1s));
          st_q      <= corr_pkg::ST_OUT;
        end
        corr_pkg::ST_OUT: begin
          acc_q     <= s1;
          sat_acc_q <= sat_acc_q | m1s | a1s;
          st_q      <= corr_pkg::ST_DONE;
        end
        corr_pkg::ST_DONE: begin
          res_q     <= raw_q ? res_q : s1;
          sat_q     <= raw_q ? 1'b0 : (sat_acc_q | m2s | a1s);
          busy_q    <= 1'b0;
          st_q      <= corr_pkg::ST_IDLE;
        end
        default: begin
          st_q <= corr_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // ==========================================================================
  // Sample converter inputs while idle
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sraw_q <= '0;
      traw_q <= '0;
    end else if (st_q == corr_pkg::ST_IDLE) begin
      sraw_q <= i_sraw;
      traw_q <= i_traw;
    end
  end
  // ==========================================================================
  // APB slave, zero wait states
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && !i_penable && !i_pwrite;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg02_q <= '0;
      cfg12_q <= corr_pkg::CFG12_RST;
      cfg19_q <= '0;
      for (int i = 0; i < corr_pkg::N_COEF; i++) coef_q[i] <= '0;
    end else if (wr_en) begin
      case (i_paddr)
        corr_pkg::A_CFG02: cfg02_q <= i_pwdata[15:0];
        corr_pkg::A_CFG12: cfg12_q <= i_pwdata[15:0];
        corr_pkg::A_CFG19: cfg19_q <= i_pwdata[15:0];
        default: begin
          for (int i = 0; i < corr_pkg::N_COEF; i++)
            if (i_paddr == 8'(corr_pkg::A_COEF0 + 4 * i)) coef_q[i] <= i_pwdata[23:0];
        end
      endcase
    end
  end
  always_comb begin
    rdat = '0;
    hit  = 1'b1;
    case (i_paddr)
      corr_pkg::A_CFG02:  rdat = {16'h0, cfg02_q};
      corr_pkg::A_CFG12:  rdat = {16'h0, cfg12_q};
      corr_pkg::A_CFG19:  rdat = {16'h0, cfg19_q};
      corr_pkg::A_CTRL:   rdat = '0;
      corr_pkg::A_STATUS: rdat = {26'h0, busy_q, 4'h0, sat_q};
      corr_pkg::A_RESULT: rdat = {{6{res_q[25]}}, res_q};
      corr_pkg::A_SRAW:   rdat = {{6{sraw_q[25]}}, sraw_q};
      corr_pkg::A_TRAW:   rdat = {{6{traw_q[25]}}, traw_q};
      corr_pkg::A_CONVT:  rdat = {13'h0, o_cap_conv_cycles};
      default: begin
        hit = 1'b0;
        for (int i = 0; i < corr_pkg::N_COEF; i++)
          if (i_paddr == 8'(corr_pkg::A_COEF0 + 4 * i)) begin
            rdat = {8'h0, coef_q[i]};
            hit  = 1'b1;
          end
      end
    endcase
  end
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !hit;
      if (rd_en) o_prdata <= rdat;
    end
  end
  // ==========================================================================
  // Front-end controls and conversion time
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_guard_drive_enable     <= 1'b0;
      o_difference_mode_enable <= 1'b0;
      o_noise_mode             <= 1'b0;
      o_cap_res_bits           <= '0;
      o_temp_res_bits          <= '0;
      o_cap_conv_cycles        <= '0;
      o_busy                   <= 1'b0;
      o_sat                    <= 1'b0;
    end else begin
      o_guard_drive_enable     <= cfg19_q[corr_pkg::B_GUARD];
      o_difference_mode_enable <= cfg19_q[corr_pkg::B_DIFF];
      o_noise_mode             <= cfg12_q[corr_pkg::B_NOISE];
      o_cap_res_bits  <= 5'(12 + 2 * cfg12_q[corr_pkg::B_RES_HI:corr_pkg::B_RES_LO]);
      o_temp_res_bits <= 5'(corr_pkg::TEMP_RES);
      o_cap_conv_cycles <= cfg12_q[corr_pkg::B_NOISE] ?
        19'(corr_pkg::T_N1[cfg12_q[corr_pkg::B_RES_HI:corr_pkg::B_RES_LO]] * corr_pkg::CLK_MHZ) :
        19'(corr_pkg::T_N0[cfg12_q[corr_pkg::B_RES_HI:corr_pkg::B_RES_LO]] * corr_pkg::CLK_MHZ);
      o_busy <= busy_q;
      o_sat  <= sat_q;
    end
  end
endmodule : corr_math

// ==== hdl/corr_mul.sv ====
// Scaled signed multiplier with saturation
`timescale 1ns/100ps
module corr_mul #(
  parameter int SH = 23
) (
  // Operands
  input  wire logic signed [25:0] i_a,
  input  wire logic signed [25:0] i_b,
  // Result
  output logic signed [25:0]      o_p,
  output logic                    o_sat
);
  logic signed [51:0] prod;
  logic signed [51:0] scl;
  always_comb begin
    prod = i_a * i_b;
    scl  = prod >>> SH;
    o_sat = 1'b0;
    o_p   = scl[25:0];
    if (scl > 52'(corr_pkg::MAX_V)) begin
      o_p   = corr_pkg::MAX_V;
      o_sat = 1'b1;
    end else if (scl < 52'(corr_pkg::MIN_V)) begin
      o_p   = corr_pkg::MIN_V;
      o_sat = 1'b1;
    end
  end
endmodule : corr_mul

// ==== hdl/corr_pkg.sv ====
// Package of constants for the capacitive sensor correction datapath
package corr_pkg;
  // ==========================================================================
  // Arithmetic format
  localparam int DW        = 26;
  localparam int CW        = 24;
  localparam int MAG_W     = 23;
  localparam int PW        = 52;
  localparam int SCALE_SH  = 23;
  localparam int LOAD_SH   = 2;
  localparam int GAIN_SH   = 21;
  localparam logic signed [DW-1:0] MAX_V   = 26'sh1ffffff;
  localparam logic signed [DW-1:0] MIN_V   = -26'sh2000000;
  localparam logic signed [DW-1:0] ONE_V   = 26'sh0800000;
  localparam logic signed [DW-1:0] INV_OFS = 26'sh1000000;
  localparam logic [47:0]          INV_NUM = 48'h4000_0000_0000;
  // ==========================================================================
  // APB register byte addresses
  localparam logic [7:0] A_CFG02   = 8'h00;
  localparam logic [7:0] A_CFG12   = 8'h04;
  localparam logic [7:0] A_CFG19   = 8'h08;
  localparam logic [7:0] A_CTRL    = 8'h0c;
  localparam logic [7:0] A_STATUS  = 8'h10;
  localparam logic [7:0] A_RESULT  = 8'h14;
  localparam logic [7:0] A_SRAW    = 8'h18;
  localparam logic [7:0] A_TRAW    = 8'h1c;
  localparam logic [7:0] A_COEF0   = 8'h20;
  localparam int         N_COEF    = 9;
  localparam logic [7:0] A_CONVT   = 8'h44;
  // Coefficient indices
  localparam int C_GAIN = 0, C_OFS = 1, C_TCG = 2, C_TCO = 3, C_STCG = 4;
  localparam int C_STCO = 5, C_SSEN = 6, C_SHIFT = 7, C_SPARE = 8;
  // ==========================================================================
  // Field positions
  localparam int B_INV      = 11;
  localparam int B_SHAPE    = 15;
  localparam int B_NOISE    = 8;
  localparam int B_RES_HI   = 7;
  localparam int B_RES_LO   = 6;
  localparam int B_GUARD    = 4;
  localparam int B_DIFF     = 3;
  localparam int B_START    = 0;
  localparam int B_RAWCMD   = 1;
  localparam int B_OTHER    = 2;
  localparam int B_SAT      = 0;
  localparam int B_BUSY     = 5;
  localparam logic [15:0] CFG12_RST = 16'h0080;
  // ==========================================================================
  // Conversion times in microseconds, and cycle counts at 40 MHz
  localparam int CLK_MHZ = 40;
  localparam int T_N0 [4] = '{770, 1310, 2390, 4550};
  localparam int T_N1 [4] = '{1550, 2850, 5440, 10620};
  localparam int T_TEMP_US = 1040;
  localparam int TEMP_RES  = 14;
  localparam int TEMP_CYC  = T_TEMP_US * CLK_MHZ;
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_INV = 3'b001, ST_TEMP = 3'b010,
    ST_GAIN = 3'b011, ST_OUT = 3'b100, ST_DONE = 3'b101
  } state_t;
endpackage : corr_pkg
